// *** nco_pkg.sv ***
// Purpose: Shared constants for the phase accumulator register bank
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per word
// Notes:   Register values sit in the low byte, upper bits read as zero
package nco_pkg;
   localparam int ACC_W  = 20;
   localparam int REG_W  = 8;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;

   // Byte offsets
   localparam logic [5:0] OFS_ACC_LOW   = 6'h00;
   localparam logic [5:0] OFS_ACC_HIGH  = 6'h04;
   localparam logic [5:0] OFS_ACC_UPPER = 6'h08;
   localparam logic [5:0] OFS_INC_LOW   = 6'h0C;
   localparam logic [5:0] OFS_INC_HIGH  = 6'h10;
   localparam logic [5:0] OFS_INC_UPPER = 6'h14;
   localparam logic [5:0] OFS_CLK_CTRL  = 6'h18;
   localparam logic [5:0] OFS_CONTROL   = 6'h1C;
   localparam logic [5:0] OFS_IRQ_STAT  = 6'h20;
   localparam logic [5:0] OFS_IRQ_MASK  = 6'h24;

   // Control register fields
   localparam int CON_EN_BIT  = 7;
   localparam int CON_OUT_BIT = 5;
   localparam int CON_POL_BIT = 4;
   localparam int CON_PFM_BIT = 0;
   // Clock control fields
   localparam int CLK_PWS_LSB = 5;
   localparam int CLK_PWS_W   = 3;
   localparam int CLK_CKS_LSB = 0;
   localparam int CLK_CKS_W   = 2;
   // Interrupt status fields
   localparam int IRQ_OVF_BIT = 0;
   localparam int IRQ_W       = 1;

   // Clock source codes
   localparam logic [1:0] CKS_INTERNAL = 2'h0;
   localparam logic [1:0] CKS_SYSTEM   = 2'h1;
   localparam logic [1:0] CKS_LOGIC    = 2'h2;

   // Reset values
   localparam logic [19:0] ACC_RST = 20'h0_0000;
   localparam logic [19:0] INC_RST = 20'h0_0001;
   localparam logic [7:0]  CON_RST = 8'h00;
   localparam logic [7:0]  CLK_RST = 8'h00;

   // Oscillator clock edges from a step-value low write to the commit
   localparam logic [1:0] COMMIT_TICKS = 2'h2;
   // Default internal source divider, in system clock cycles
   localparam int HF_DIV_DEF = 6;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } nco_bus_e;
endpackage

// *** nco_outstage.sv ***
// Purpose: Output stage driven by accumulator overflow
// Assumes: tick is one system cycle per oscillator clock edge
// Notes:   Output level is registered, polarity applied last
module nco_outstage (
   input  wire logic       clk,        // System clock
   input  wire logic       rstn,       // Synchronous reset, active low
   input  wire logic       en,         // Oscillator enable
   input  wire logic       tick,       // Oscillator clock edge
   input  wire logic       ovf,        // Accumulator overflow this tick
   input  wire logic       pfm,        // Pulse frequency mode
   input  wire logic [2:0] pws,        // Pulse width select
   input  wire logic       pol,        // Active low when set
   output logic            out_level   // Output pin level
);
   logic       state_reg;
   logic [7:0] width_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_reg <= 1'b0;
         width_reg <= 8'h00;
      end else if (!en) begin
         state_reg <= 1'b0;
         width_reg <= 8'h00;
      end else if (tick) begin
         if (ovf && !pfm) begin
            state_reg <= ~state_reg;                              // R11
         end else if (ovf && pfm) begin
            state_reg <= 1'b1;                                    // R12
            width_reg <= 8'((9'h001 << pws) - 9'h001);
         end else if (pfm && state_reg) begin
            if (width_reg == 8'h00) begin
               state_reg <= 1'b0;                                 // R12
            end else begin
               width_reg <= width_reg - 8'h01;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_level <= 1'b0;
      end else begin
         out_level <= state_reg ^ pol;
      end
   end

   fdc_toggle_a: assert property (en && tick && ovf && !pfm |=> // R11
         state_reg != $past(state_reg))
      else $error("output did not toggle on overflow");

   pulse_start_a: assert property (en && tick && ovf && pfm ##1 en // R12
         |-> state_reg && width_reg == 8'((9'h001 << $past(pws)) - 9'h001))
      else $error("pulse did not start with the selected width");

   pulse_end_a: assert property (en && tick && pfm && !ovf && state_reg // R12
         && width_reg == 8'h00 |=> !state_reg)
      else $error("pulse did not end after its width");
endmodule

// *** nco_regs.sv ***
// Purpose: Register bank and phase accumulator of a numerically controlled oscillator
// Assumes: Avalon-MM slave, every access answered after one wait cycle
// Notes:   Oscillator clock is a one-cycle enable chosen from three sources
//
// How it works
// R1 - Accumulator bits 7:0 are the low register
// R2 - Accumulator bits 15:8 are the high register
// R3 - Accumulator bits 19:16 in upper, rest zero
// R4 - Step low register, resets to one
// R5 - Step high register, resets to zero
// R6 - Step bits 19:16 in upper, rest zero
// R7 - Software writes step high bytes before low
// R8 - Accumulator and step high bytes reset zero
// R9 - Each oscillator edge adds buffered step
// R10 - Low write commits step on second edge
// R11 - Fixed duty mode toggles output per overflow
// R12 - Pulse mode holds output for selected periods
// R13 - Accumulator byte write replaces only that byte
// R14 - Step reads return software values, not buffer
module nco_regs #(
   parameter int HF_DIV = nco_pkg::HF_DIV_DEF
) (
   input  wire logic        MCLK,           // System clock, 100 MHz
   input  wire logic        RSTN,           // Synchronous reset, active low
   input  wire logic [5:0]  AVS_ADDRESS,    // Byte address
   input  wire logic        AVS_READ,       // Read request
   input  wire logic        AVS_WRITE,      // Write request
   input  wire logic [3:0]  AVS_BYTEENABLE, // Byte lanes
   input  wire logic [31:0] AVS_WRITEDATA,  // Write data
   output logic [31:0]      AVS_READDATA,   // Read data
   output logic             AVS_WAITREQUEST,// Stall
   input  wire logic        LOGIC_CLK_TICK, // Logic-cell clock edge pulse
   output logic             NCO_OUT,        // Oscillator output
   output logic             ACCUM_OVERFLOW,   // Overflow pulse
   output logic             IRQ             // Interrupt, active high
);
   localparam int DIV_W = $clog2(HF_DIV + 1);

   if (HF_DIV < 1) begin : g_chk
      $error("HF_DIV must be at least one");
   end

   nco_pkg::nco_bus_e bus_reg;
   logic [19:0]       acc_reg;
   logic [19:0]       inc_sw_reg;
   logic [19:0]       inc_buf_reg;
   logic [1:0]        commit_cnt_reg;
   logic [7:0]        con_reg;
   logic [7:0]        clk_ctrl_reg;
   logic              irq_stat_reg;
   logic              irq_mask_reg;
   logic [31:0]       rdata_next;
   logic [DIV_W-1:0]  div_reg;
   logic              hf_tick;
   logic              osc_tick;
   logic [20:0]       sum;
   logic              ovf;
   logic              wr_fire;
   logic              lane0;
   logic              osc_en;
   logic              out_level;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   assign osc_en  = con_reg[nco_pkg::CON_EN_BIT];
   assign lane0   = AVS_BYTEENABLE[0];
   assign wr_fire = AVS_WRITE && (bus_reg == nco_pkg::BUS_ACK) && lane0;

   // Bus handshake: one wait cycle, answer in the second cycle
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (bus_reg == nco_pkg::BUS_IDLE);

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         bus_reg <= nco_pkg::BUS_IDLE;
      end else begin
         case (bus_reg)
            nco_pkg::BUS_IDLE: begin
               if (AVS_READ || AVS_WRITE) begin
                  bus_reg <= nco_pkg::BUS_ACK;
               end
            end
            nco_pkg::BUS_ACK: begin
               bus_reg <= nco_pkg::BUS_IDLE;
            end
            default: begin
               bus_reg <= nco_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // Internal oscillator source divided from the system clock
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         div_reg <= '0;
      end else if (div_reg == DIV_W'(HF_DIV - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end
   assign hf_tick = (div_reg == DIV_W'(HF_DIV - 1));

   always_comb begin
      case (clk_ctrl_reg[nco_pkg::CLK_CKS_LSB +: nco_pkg::CLK_CKS_W])
         nco_pkg::CKS_INTERNAL: osc_tick = hf_tick;
         nco_pkg::CKS_SYSTEM:   osc_tick = 1'b1;
         nco_pkg::CKS_LOGIC:    osc_tick = LOGIC_CLK_TICK;
         default:               osc_tick = 1'b0;
      endcase
   end

   assign sum = {1'b0, acc_reg} + {1'b0, inc_buf_reg};
   assign ovf = osc_en && osc_tick && sum[20];

   // Accumulator: adder on oscillator edges, byte writes override
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         acc_reg <= nco_pkg::ACC_RST;                             // R8
      end else begin
         if (osc_en && osc_tick) begin
            acc_reg <= sum[19:0];                                 // R9
         end
         if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_ACC_LOW) begin
            acc_reg[7:0] <= AVS_WRITEDATA[7:0];                   // R1
         end
         if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_ACC_HIGH) begin
            acc_reg[15:8] <= AVS_WRITEDATA[7:0];                  // R13
         end
         if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_ACC_UPPER) begin
            acc_reg[19:16] <= AVS_WRITEDATA[3:0];                 // R3
         end
      end
   end

   // Software-visible step value
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         inc_sw_reg <= nco_pkg::INC_RST;                          // R4
      end else if (wr_fire) begin
         case (AVS_ADDRESS)
            nco_pkg::OFS_INC_LOW:   inc_sw_reg[7:0]   <= AVS_WRITEDATA[7:0]; // R4
            nco_pkg::OFS_INC_HIGH:  inc_sw_reg[15:8]  <= AVS_WRITEDATA[7:0]; // R5
            nco_pkg::OFS_INC_UPPER: inc_sw_reg[19:16] <= AVS_WRITEDATA[3:0]; // R6
            default:                inc_sw_reg        <= inc_sw_reg;
         endcase
      end
   end

   // Buffered step: commits on the second oscillator edge after a low write, follows the software value while disabled
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         inc_buf_reg    <= nco_pkg::INC_RST;
         commit_cnt_reg <= 2'h0;
      end else if (!osc_en) begin
         inc_buf_reg    <= inc_sw_reg;                            // R10
         commit_cnt_reg <= 2'h0;
      end else if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_INC_LOW) begin
         commit_cnt_reg <= nco_pkg::COMMIT_TICKS;                 // R7
      end else if (commit_cnt_reg != 2'h0 && osc_tick) begin
         commit_cnt_reg <= commit_cnt_reg - 2'h1;
         if (commit_cnt_reg == 2'h1) begin
            inc_buf_reg <= inc_sw_reg;                            // R10
         end
      end
   end

   // Control and clock selection registers
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         con_reg      <= nco_pkg::CON_RST;
         clk_ctrl_reg <= nco_pkg::CLK_RST;
      end else if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_CONTROL) begin
         con_reg[nco_pkg::CON_EN_BIT]  <= AVS_WRITEDATA[nco_pkg::CON_EN_BIT];
         con_reg[nco_pkg::CON_POL_BIT] <= AVS_WRITEDATA[nco_pkg::CON_POL_BIT];
         con_reg[nco_pkg::CON_PFM_BIT] <= AVS_WRITEDATA[nco_pkg::CON_PFM_BIT];
      end else if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_CLK_CTRL) begin
         clk_ctrl_reg[nco_pkg::CLK_PWS_LSB +: nco_pkg::CLK_PWS_W] <=
            AVS_WRITEDATA[nco_pkg::CLK_PWS_LSB +: nco_pkg::CLK_PWS_W];
         clk_ctrl_reg[nco_pkg::CLK_CKS_LSB +: nco_pkg::CLK_CKS_W] <=
            AVS_WRITEDATA[nco_pkg::CLK_CKS_LSB +: nco_pkg::CLK_CKS_W];
      end
   end

   // Sticky overflow flag, write one to clear, a new overflow wins
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         irq_stat_reg <= 1'b0;
      end else if (ovf) begin
         irq_stat_reg <= 1'b1;
      end else if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_IRQ_STAT
                   && AVS_WRITEDATA[nco_pkg::IRQ_OVF_BIT]) begin
         irq_stat_reg <= 1'b0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         irq_mask_reg <= 1'b0;
      end else if (wr_fire && AVS_ADDRESS == nco_pkg::OFS_IRQ_MASK) begin
         irq_mask_reg <= AVS_WRITEDATA[nco_pkg::IRQ_OVF_BIT];
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         IRQ          <= 1'b0;
         ACCUM_OVERFLOW <= 1'b0;
      end else begin
         IRQ          <= irq_stat_reg && irq_mask_reg;
         ACCUM_OVERFLOW <= ovf;
      end
   end

   nco_outstage u_out (
      .clk       (MCLK),
      .rstn      (RSTN),
      .en        (osc_en),
      .tick      (osc_tick),
      .ovf       (ovf),
      .pfm       (con_reg[nco_pkg::CON_PFM_BIT]),
      .pws       (clk_ctrl_reg[nco_pkg::CLK_PWS_LSB +: nco_pkg::CLK_PWS_W]),
      .pol       (con_reg[nco_pkg::CON_POL_BIT]),
      .out_level (out_level)
   );
   assign NCO_OUT = out_level;

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (AVS_ADDRESS)
         nco_pkg::OFS_ACC_LOW:   rdata_next[7:0] = acc_reg[7:0];      // R1
         nco_pkg::OFS_ACC_HIGH:  rdata_next[7:0] = acc_reg[15:8];     // R2
         nco_pkg::OFS_ACC_UPPER: rdata_next[3:0] = acc_reg[19:16];    // R3
         nco_pkg::OFS_INC_LOW:   rdata_next[7:0] = inc_sw_reg[7:0];   // R14
         nco_pkg::OFS_INC_HIGH:  rdata_next[7:0] = inc_sw_reg[15:8];  // R14
         nco_pkg::OFS_INC_UPPER: rdata_next[3:0] = inc_sw_reg[19:16]; // R6
         nco_pkg::OFS_CLK_CTRL:  rdata_next[7:0] = clk_ctrl_reg;
         nco_pkg::OFS_CONTROL: begin
            rdata_next[7:0] = con_reg;
            rdata_next[nco_pkg::CON_OUT_BIT] = out_level;
         end
         nco_pkg::OFS_IRQ_STAT:  rdata_next[nco_pkg::IRQ_OVF_BIT] = irq_stat_reg;
         nco_pkg::OFS_IRQ_MASK:  rdata_next[nco_pkg::IRQ_OVF_BIT] = irq_mask_reg;
         default:                rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ && bus_reg == nco_pkg::BUS_IDLE) begin
         AVS_READDATA <= rdata_next;                              // R14
      end
   end

   // Checks
   sequence low_commit_s;
      osc_en && commit_cnt_reg == 2'h1 && osc_tick && !wr_fire;
   endsequence

   sequence still_on_s;
      osc_en;
   endsequence

   acc_step_a: assert property (osc_en && osc_tick && !wr_fire |=> // R9
         acc_reg == $past(sum[19:0]))
      else $error("accumulator did not add the step");

   reset_vals_a: assert property ($past(!RSTN) |-> acc_reg == 20'h0_0000 // R8
         && inc_sw_reg == 20'h0_0001)
      else $error("wrong reset values");

   commit_two_a: assert property (low_commit_s ##1 still_on_s // R10
         |-> inc_buf_reg == $past(inc_sw_reg))
      else $error("step buffer not committed on second edge");

   arm_commit_a: assert property (osc_en && wr_fire // R10
         && AVS_ADDRESS == nco_pkg::OFS_INC_LOW |=> commit_cnt_reg == 2'h2
         && inc_buf_reg == $past(inc_buf_reg))
      else $error("low step write did not arm the commit");

   off_load_a: assert property (!osc_en |=> inc_buf_reg == $past(inc_sw_reg)) // R10
      else $error("disabled step buffer not loaded at once");

   byte_wr_a: assert property (wr_fire && AVS_ADDRESS == nco_pkg::OFS_ACC_HIGH // R13
         |=> acc_reg[15:8] == $past(AVS_WRITEDATA[7:0])
         && acc_reg[7:0] == $past(osc_en && osc_tick ? sum[7:0] : acc_reg[7:0]))
      else $error("accumulator byte write disturbed other bytes");

   upper_zero_a: assert property (bus_reg == nco_pkg::BUS_ACK && AVS_READ // R3
         && (AVS_ADDRESS == nco_pkg::OFS_ACC_UPPER
         || AVS_ADDRESS == nco_pkg::OFS_INC_UPPER) |-> AVS_READDATA[31:4] == 28'h000_0000)
      else $error("upper register unused bits not zero");

   step_read_a: assert property (bus_reg == nco_pkg::BUS_ACK && AVS_READ // R14
         && AVS_ADDRESS == nco_pkg::OFS_INC_LOW
         |-> AVS_READDATA == {24'h00_0000, $past(inc_sw_reg[7:0])})
      else $error("step low read wrong");

   irq_set_a: assert property (ovf |=> irq_stat_reg ##1 IRQ == irq_mask_reg)
      else $error("overflow flag or interrupt wrong");
endmodule

// *** nco_regs_tb.sv ***
// Purpose: Self-checking bench for the oscillator register bank
// Assumes: Oscillator clocked from LOGIC_CLK_TICK except in the free-running source pass, ticks spaced by idle cycles
// Notes:   Bench model tracks accumulator, step buffer and overflow count
module nco_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        MCLK           = 1'b0;
   logic        RSTN           = 1'b0;
   logic [5:0]  AVS_ADDRESS    = 6'h00;
   logic        AVS_READ       = 1'b0;
   logic        AVS_WRITE      = 1'b0;
   logic [3:0]  AVS_BYTEENABLE = 4'h0;
   logic [31:0] AVS_WRITEDATA  = 32'h0000_0000;
   logic        LOGIC_CLK_TICK = 1'b0;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic        NCO_OUT;
   logic        ACCUM_OVERFLOW;
   logic        IRQ;
   int          num_errors     = 0;
   int          checks         = 0;
   int          seed           = 10454;
   int          ovf_seen       = 0;
   int          ovf_base;
   int          ovf_m;
   int          acc_m;
   int          inc_m;
   int          hi_cnt;
   logic [31:0] q;
   logic [31:0] d;
   logic [31:0] s2;
   logic [31:0] v [6];

   nco_regs uut (
      .MCLK            (MCLK),
      .RSTN            (RSTN),
      .AVS_ADDRESS     (AVS_ADDRESS),
      .AVS_READ        (AVS_READ),
      .AVS_WRITE       (AVS_WRITE),
      .AVS_BYTEENABLE  (AVS_BYTEENABLE),
      .AVS_WRITEDATA   (AVS_WRITEDATA),
      .AVS_READDATA    (AVS_READDATA),
      .AVS_WAITREQUEST (AVS_WAITREQUEST),
      .LOGIC_CLK_TICK  (LOGIC_CLK_TICK),
      .NCO_OUT         (NCO_OUT),
      .ACCUM_OVERFLOW    (ACCUM_OVERFLOW),
      .IRQ             (IRQ)
   );

   always #5 MCLK = ~MCLK;

   always @(posedge MCLK) begin
      if (ACCUM_OVERFLOW === 1'b1) ovf_seen <= ovf_seen + 1;
   end

   task automatic results();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask

   // Holds the request until waitrequest is seen low at a falling edge, then through the next rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [3:0] be,
                      input logic [31:0] dd, output logic [31:0] rq);
      int   n;
      logic w;
      n = 0;
      AVS_ADDRESS    <= a;
      AVS_WRITE      <= wr;
      AVS_READ       <= ~wr;
      AVS_BYTEENABLE <= be;
      AVS_WRITEDATA  <= dd;
      do begin
         @(negedge MCLK);
         w = AVS_WAITREQUEST;
         @(posedge MCLK);
         n++;
      end while (w !== 1'b0 && n < 20);
      rq = AVS_READDATA;
      chk("bus answer", 32'h0000_0000, 32'(w));
      AVS_READ  <= 1'b0;
      AVS_WRITE <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] dd);
      bus(1'b1, a, 4'hF, dd, q);
   endtask

   task automatic rc(input logic [5:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 4'hF, 32'h0000_0000, q);
      chk(nm, e, q);
   endtask

   task automatic set_acc(input logic [31:0] val);
      wr(nco_pkg::OFS_ACC_LOW, val);
      wr(nco_pkg::OFS_ACC_HIGH, val >> 8);
      wr(nco_pkg::OFS_ACC_UPPER, val >> 16);
      acc_m = int'(val);
   endtask

   // Upper and high first, low last so the low write commits the whole value
   task automatic set_inc(input logic [31:0] val);
      wr(nco_pkg::OFS_INC_UPPER, val >> 16);
      wr(nco_pkg::OFS_INC_HIGH, val >> 8);
      wr(nco_pkg::OFS_INC_LOW, val);
      inc_m = int'(val);
   endtask

   task automatic chk_acc();
      rc(nco_pkg::OFS_ACC_LOW, acc_m & 32'h0000_00FF, "acc low");
      rc(nco_pkg::OFS_ACC_HIGH, (acc_m >> 8) & 32'h0000_00FF, "acc high");
      rc(nco_pkg::OFS_ACC_UPPER, (acc_m >> 16) & 32'h0000_000F, "acc upper");
   endtask

   // One oscillator edge per call step, output sampled once settled
   task automatic tick(input int n);
      repeat (n) begin
         LOGIC_CLK_TICK <= 1'b1;
         @(posedge MCLK);
         LOGIC_CLK_TICK <= 1'b0;
         ovf_m += (acc_m + inc_m) >> 20;
         acc_m = (acc_m + inc_m) & 32'h000F_FFFF;
         repeat (3) @(posedge MCLK);
         if (NCO_OUT === 1'b1) hi_cnt++;
         @(posedge MCLK);
      end
   endtask

   task automatic do_reset();
      RSTN <= 1'b0;
      repeat (3) @(posedge MCLK);
      RSTN <= 1'b1;
      @(posedge MCLK);
      acc_m = 0;
      inc_m = 1;
   endtask

   task automatic chk_rst();
      for (int i = 0; i < 10; i++) begin
         rc(6'(i * 4), (i == 3) ? 32'h0000_0001 : 32'h0000_0000, "reset value");
      end
      chk("out idle", 32'h0000_0000, 32'(NCO_OUT));
   endtask

   initial begin
      repeat (20000) @(posedge MCLK);
      $display("[FAIL] watchdog expected finish seen hang");
      num_errors++;
      results();
   end

   initial begin
      @(posedge MCLK);
      do_reset();
      chk_rst();
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         v[i] = d & ((i % 3 == 2) ? 32'h0000_000F : 32'h0000_00FF);
         wr(6'(i * 4), d);
         rc(6'(i * 4), v[i], "value reg");
      end
      wr(6'h28, 32'h0000_00FF);
      rc(6'h28, 32'h0000_0000, "unmapped");
      bus(1'b1, nco_pkg::OFS_ACC_LOW, 4'hE, 32'h0000_0055, q);
      rc(nco_pkg::OFS_ACC_LOW, v[0], "lane off");
      // Adder and fixed duty output from bench-driven oscillator edges
      wr(nco_pkg::OFS_CLK_CTRL, 32'(nco_pkg::CKS_LOGIC));
      set_acc(32'h000F_FF00);
      set_inc(($random(seed) & 32'h0003_FFFF) | 32'h0000_0100);
      ovf_m = 0;
      ovf_base = ovf_seen;
      wr(nco_pkg::OFS_CONTROL, 32'h0000_0080);
      tick(20);
      chk_acc();
      chk("overflows", ovf_m, ovf_seen - ovf_base);
      chk("toggle out", ovf_m & 1, 32'(NCO_OUT));
      d = $random(seed);
      wr(nco_pkg::OFS_ACC_HIGH, d);
      acc_m = (acc_m & 32'h000F_00FF) | ((d & 32'h0000_00FF) << 8);
      chk_acc();
      // Step change while running: old step holds until the commit
      s2 = $random(seed) & 32'h000F_FFFF;
      wr(nco_pkg::OFS_INC_UPPER, s2 >> 16);
      wr(nco_pkg::OFS_INC_HIGH, s2 >> 8);
      wr(nco_pkg::OFS_INC_LOW, s2);
      rc(nco_pkg::OFS_INC_UPPER, s2 >> 16, "step upper");
      rc(nco_pkg::OFS_INC_HIGH, (s2 >> 8) & 32'h0000_00FF, "step high");
      tick(1);
      chk_acc();
      tick(1);
      chk_acc();
      set_acc(32'h0000_0000);
      inc_m = int'(s2);
      tick(3);
      chk_acc();
      // Overflow interrupt: sticky status, mask, write-one clear
      chk("irq masked", 32'h0000_0000, 32'(IRQ));
      rc(nco_pkg::OFS_IRQ_STAT, 32'h0000_0001, "irq status");
      wr(nco_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge MCLK);
      chk("irq raised", 32'h0000_0001, 32'(IRQ));
      wr(nco_pkg::OFS_CONTROL, 32'h0000_0000);
      wr(nco_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge MCLK);
      chk("irq cleared", 32'h0000_0000, 32'(IRQ));
      rc(nco_pkg::OFS_IRQ_STAT, 32'h0000_0000, "irq status");
      // Pulse mode widths, odd passes with inverted polarity
      set_inc(32'h0001_0000);
      for (int s = 0; s < 3; s++) begin
         set_acc(32'h000F_0000);
         wr(nco_pkg::OFS_CLK_CTRL, (s << 5) | 32'(nco_pkg::CKS_LOGIC));
         wr(nco_pkg::OFS_CONTROL, 32'h0000_0081 | ((s % 2) << 4));
         hi_cnt = 0;
         tick(16);
         chk("pulse span", (s % 2) ? 16 - (1 << s) : (1 << s), hi_cnt);
         wr(nco_pkg::OFS_CONTROL, 32'h0000_0000);
      end
      // Internal and system sources, and the unused code 3, over a six-cycle enable window
      for (int c = 0; c < 4; c++) begin
         if (c != 2) begin
            wr(nco_pkg::OFS_CLK_CTRL, 32'(c));
            set_acc(32'h0000_0000);
            wr(nco_pkg::OFS_CONTROL, 32'h0000_0080);
            repeat (3) @(posedge MCLK);
            wr(nco_pkg::OFS_CONTROL, 32'h0000_0000);
            acc_m = ((c == 0) ? inc_m : (c == 1) ? 6 * inc_m : 0) & 32'h000F_FFFF;
            chk_acc();
         end
      end
      do_reset();
      chk_rst();
      results();
   end
endmodule
